// File: fan_monitor_config_regs.sv
// Configuration register bank of the fan monitor with its control outputs
//
// Functional notes
// [R1] Quick sampling bit selects one or four fan speed measurements per second.
// [R2] PWM mode bit picks low-frequency programmable PWM or fixed 22.5 kHz.
// [R3] Hot input 1 forces full speed unless its ignore bit is set.
// [R4] Hot input 2 forces full speed unless its ignore bit is set.
// [R5] Full speed bit forces every fan output to full speed; default zero.
// [R6] Low-frequency PWM mode stretches PWM pulses for accurate speed measurement.
// [R7] Window code 00..11 measures one to four pulses after second edge.
// [R8] Pin functions stay disabled until pin enable bit is set.
// [R9] Clock line timeout enable bit, disabled at reset.
// [R10] Data line timeout enable bit, disabled at reset.
// [R11] Intrusion clear bit resets the latch, then clears itself.
// [R12] Parity-chain test mode follows its bit; clear returns to normal.
// [R13] Pulse input n measured only while its enable bit is set.
// [R14] Pair continuous bits disable stretching and sync; reset to ones. Here they gate only pulse_stretch_en; pulse inputs are always synchronised.
// [R15] Upper four pulse configuration bits read zero and ignore writes.
// [R16] Pin polarity on even bits, direction on odd bits, reset zero.
// [R17] Lock bit makes all these registers read-only until power cycles.
// [R18] Keyed software reset restores unlocked registers; reset bit self-clears.
// [R19] Reserved read-write bits hold writes, reset to zero, affect nothing.
//
// Our own choice: strobed register access.
`timescale 1ns/1ps
module fan_monitor_config_regs
    import fan_cfg_pkg::*;
#(
    parameter int SLOW_CYCLES = SLOW_MEAS_CYCLES,
    parameter int FAST_CYCLES = FAST_MEAS_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic regulator_hot_input_1,
    input wire logic regulator_hot_input_2,
    input wire logic [7:0] fan_speed_pulse_input,
    output logic fan_full_speed,
    output logic pwm_high_freq,
    output logic [1:0] speed_pulse_window,
    output logic [7:0] pulse_measure_en,
    output logic [7:0] pulse_stretch_en,
    output logic [7:0] pulse_measure_edge,
    output logic meas_tick,
    output logic pin_enable,
    output logic [3:0] pin1_4_polarity,
    output logic [3:0] pin1_4_direction,
    output logic scl_timeout_en,
    output logic sda_timeout_en,
    output logic intrusion_latch_clear,
    output logic parity_chain_test,
    output logic config_locked
);

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [7:0] fan_pwm_config;
        logic [7:0] misc_system_config;
        logic [7:0] fan_pulse_enable;
        logic [3:0] fan_pulse_config;
        logic [7:0] pin_polarity_direction_1;
        logic soft_reset_armed;
        logic locked;
        logic [7:0] rdata;
        logic [1:0] hot1_sync;
        logic [1:0] hot2_sync;
        logic [7:0] pulse_s1;
        logic [7:0] pulse_s2;
        logic [7:0] pulse_s3;
        logic full_speed;
        logic intrusion_clear;
        logic [7:0] meas_en;
        logic [7:0] stretch_en;
        logic [7:0] meas_edge;
        logic [3:0] pin_pol;
        logic [3:0] pin_dir;
    } regs_state_t;

    regs_state_t s_q;
    regs_state_t s_d;
    logic tick;

    // Write-enable decode, shared by every writable register
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off, input logic w);
        return w && (a == off);
    endfunction

    // ****************************************
    // Measurement interval
    // ****************************************
    meas_tick_gen #(
        .SLOW_CYCLES(SLOW_CYCLES),
        .FAST_CYCLES(FAST_CYCLES)
    ) u_tick (
        .ref_clk(ref_clk),
        .rst(rst),
        .clk_en(clk_en),
        .quick(s_q.fan_pwm_config[BIT_QUICK_SAMPLING]), // R1
        .tick(tick)
    );

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        logic hot1;
        logic hot2;
        logic low_freq;
        logic wr_ok;
        logic [7:0] rise;
        hot1 = 1'b0;
        hot2 = 1'b0;
        low_freq = 1'b0;
        wr_ok = 1'b0;
        rise = '0;
        s_d = s_q;

        // Pin inputs pass two flops before use
        s_d.hot1_sync = {s_q.hot1_sync[0], regulator_hot_input_1};
        s_d.hot2_sync = {s_q.hot2_sync[0], regulator_hot_input_2};
        s_d.pulse_s1 = fan_speed_pulse_input;
        s_d.pulse_s2 = s_q.pulse_s1;
        s_d.pulse_s3 = s_q.pulse_s2;
        hot1 = s_q.hot1_sync[1];
        hot2 = s_q.hot2_sync[1];
        rise = s_q.pulse_s2 & ~s_q.pulse_s3;

        wr_ok = reg_wr && !s_q.locked; // R17

        // Self-clearing intrusion clear
        s_d.misc_system_config[BIT_INTRUSION_CLEAR] = 1'b0; // R11

        if (hit(reg_addr, OFF_FAN_PWM_CONFIG, wr_ok)) begin
            s_d.fan_pwm_config = reg_wdata; // R19
        end
        if (hit(reg_addr, OFF_MISC_SYSTEM_CONFIG, wr_ok)) begin
            s_d.misc_system_config = reg_wdata; // R11
        end
        if (hit(reg_addr, OFF_FAN_PULSE_ENABLE, wr_ok)) begin
            s_d.fan_pulse_enable = reg_wdata;
        end
        if (hit(reg_addr, OFF_FAN_PULSE_CONFIG, wr_ok)) begin
            s_d.fan_pulse_config = reg_wdata[3:0]; // R15
        end
        if (hit(reg_addr, OFF_PIN_POLARITY_DIRECTION_1, wr_ok)) begin
            s_d.pin_polarity_direction_1 = reg_wdata;
        end
        if (hit(reg_addr, OFF_LOCK_CTRL, reg_wr) && reg_wdata[BIT_LOCK]) begin
            s_d.locked = 1'b1; // R17
        end
        if (hit(reg_addr, OFF_SOFT_RESET_UNLOCK, reg_wr)) begin
            s_d.soft_reset_armed = (reg_wdata == SOFT_RESET_KEY); // R18
        end
        if (hit(reg_addr, OFF_SOFT_RESET_CTRL, reg_wr) && reg_wdata[BIT_SOFT_RESET]
            && s_q.soft_reset_armed) begin
            s_d.soft_reset_armed = 1'b0;
            if (!s_q.locked) begin
                s_d.fan_pwm_config = RST_FAN_PWM_CONFIG; // R18
                s_d.misc_system_config = RST_MISC_SYSTEM_CONFIG;
                s_d.fan_pulse_enable = RST_FAN_PULSE_ENABLE;
                s_d.fan_pulse_config = RST_FAN_PULSE_CONFIG[3:0];
                s_d.pin_polarity_direction_1 = RST_PIN_POLARITY_DIRECTION_1;
            end
        end

        // Read data one cycle after the strobe; unmapped reads return zero
        s_d.rdata = '0;
        if (reg_rd) begin
            case (reg_addr)
                OFF_FAN_PWM_CONFIG: s_d.rdata = s_q.fan_pwm_config;
                OFF_MISC_SYSTEM_CONFIG: s_d.rdata = s_q.misc_system_config;
                OFF_FAN_PULSE_ENABLE: s_d.rdata = s_q.fan_pulse_enable;
                OFF_FAN_PULSE_CONFIG: s_d.rdata = {4'h0, s_q.fan_pulse_config}; // R15
                OFF_PIN_POLARITY_DIRECTION_1: s_d.rdata = s_q.pin_polarity_direction_1;
                OFF_LOCK_CTRL: s_d.rdata = {1'b0, s_q.locked, 6'h00};
                default: s_d.rdata = '0;
            endcase
        end

        // Derived fan control from current register state
        low_freq = !s_q.fan_pwm_config[BIT_PWM_HIGH_FREQ]; // R2
        s_d.full_speed = s_q.fan_pwm_config[BIT_FANS_FULL_SPEED] // R5
            || (hot1 && !s_q.fan_pwm_config[BIT_HOT1_IGNORE]) // R3
            || (hot2 && !s_q.fan_pwm_config[BIT_HOT2_IGNORE]); // R4
        s_d.intrusion_clear = s_q.misc_system_config[BIT_INTRUSION_CLEAR]; // R11
        for (int i = 0; i < 8; i++) begin
            s_d.meas_en[i] = s_q.fan_pulse_enable[i]; // R13
            s_d.stretch_en[i] = low_freq && !s_q.fan_pulse_config[i % 4]; // R6 R14
            s_d.meas_edge[i] = s_q.fan_pulse_enable[i] && rise[i]; // R13
        end
        for (int j = 0; j < 4; j++) begin
            s_d.pin_pol[j] = s_q.misc_system_config[BIT_PIN_ENABLE]
                && s_q.pin_polarity_direction_1[2 * j]; // R8 R16
            s_d.pin_dir[j] = s_q.misc_system_config[BIT_PIN_ENABLE]
                && s_q.pin_polarity_direction_1[2 * j + 1]; // R8 R16
        end
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
            s_q.fan_pwm_config <= RST_FAN_PWM_CONFIG; // R7 R19
            s_q.misc_system_config <= RST_MISC_SYSTEM_CONFIG; // R9 R10
            s_q.fan_pulse_enable <= RST_FAN_PULSE_ENABLE;
            s_q.fan_pulse_config <= RST_FAN_PULSE_CONFIG[3:0]; // R14
            s_q.pin_polarity_direction_1 <= RST_PIN_POLARITY_DIRECTION_1;
        end else if (clk_en) begin
            s_q <= s_d;
        end
    end

    // Tick already leaves a flop in the generator
    assign meas_tick = tick; // R1
    assign reg_rdata = s_q.rdata;
    assign fan_full_speed = s_q.full_speed;
    assign pwm_high_freq = s_q.fan_pwm_config[BIT_PWM_HIGH_FREQ]; // R2
    assign speed_pulse_window = s_q.fan_pwm_config[BIT_WINDOW_LO +: 2]; // R7
    assign pulse_measure_en = s_q.meas_en;
    assign pulse_stretch_en = s_q.stretch_en;
    assign pulse_measure_edge = s_q.meas_edge;
    assign pin_enable = s_q.misc_system_config[BIT_PIN_ENABLE]; // R8
    assign pin1_4_polarity = s_q.pin_pol;
    assign pin1_4_direction = s_q.pin_dir;
    assign scl_timeout_en = s_q.misc_system_config[BIT_SCL_TIMEOUT]; // R9
    assign sda_timeout_en = s_q.misc_system_config[BIT_SDA_TIMEOUT]; // R10
    assign intrusion_latch_clear = s_q.intrusion_clear;
    assign parity_chain_test = s_q.misc_system_config[BIT_PARITY_CHAIN]; // R12
    assign config_locked = s_q.locked;
endmodule

// File: fan_cfg_pkg.sv
// Package: register map, reset values and field layouts of the fan monitor configuration bank
package fan_cfg_pkg;

    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [7:0] OFF_FAN_PWM_CONFIG = 8'h02;
    localparam logic [7:0] OFF_MISC_SYSTEM_CONFIG = 8'h03;
    localparam logic [7:0] OFF_FAN_PULSE_ENABLE = 8'h07;
    localparam logic [7:0] OFF_FAN_PULSE_CONFIG = 8'h08;
    localparam logic [7:0] OFF_PIN_POLARITY_DIRECTION_1 = 8'h09;
    localparam logic [7:0] OFF_SOFT_RESET_CTRL = 8'h00;
    localparam logic [7:0] OFF_LOCK_CTRL = 8'h01;
    localparam logic [7:0] OFF_SOFT_RESET_UNLOCK = 8'h7b;

    // ****************************************
    // Reset values and keys
    // ****************************************
    localparam logic [7:0] RST_FAN_PWM_CONFIG = 8'h80;
    localparam logic [7:0] RST_MISC_SYSTEM_CONFIG = 8'h00;
    localparam logic [7:0] RST_FAN_PULSE_ENABLE = 8'h00;
    localparam logic [7:0] RST_FAN_PULSE_CONFIG = 8'h0f;
    localparam logic [7:0] RST_PIN_POLARITY_DIRECTION_1 = 8'h00;
    localparam logic [7:0] SOFT_RESET_KEY = 8'h6d;
    localparam logic [7:0] PULSE_CONFIG_RW_MASK = 8'h0f;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int BIT_QUICK_SAMPLING = 0;
    localparam int BIT_PWM_HIGH_FREQ = 2;
    localparam int BIT_HOT1_IGNORE = 3;
    localparam int BIT_HOT2_IGNORE = 4;
    localparam int BIT_FANS_FULL_SPEED = 5;
    localparam int BIT_WINDOW_LO = 6;
    localparam int BIT_PIN_ENABLE = 0;
    localparam int BIT_SCL_TIMEOUT = 1;
    localparam int BIT_SDA_TIMEOUT = 2;
    localparam int BIT_INTRUSION_CLEAR = 5;
    localparam int BIT_PARITY_CHAIN = 6;
    localparam int BIT_SOFT_RESET = 7;
    localparam int BIT_LOCK = 6;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_HZ = 20000000;
    localparam int SLOW_MEAS_PER_S = 1;
    localparam int FAST_MEAS_PER_S = 4;
    localparam int SLOW_MEAS_CYCLES = CLK_HZ / SLOW_MEAS_PER_S;
    localparam int FAST_MEAS_CYCLES = CLK_HZ / FAST_MEAS_PER_S;

    // ****************************************
    // Carriers
    // ****************************************
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    typedef struct packed {
        logic quick_sampling;
        logic pwm_high_freq;
        logic fans_full_speed;
        logic [1:0] speed_pulse_window;
        logic pin_enable;
        logic scl_timeout_en;
        logic sda_timeout_en;
        logic intrusion_latch_clear;
        logic parity_chain_test;
        logic [7:0] pulse_input_enable;
        logic [7:0] pulse_stretch_en;
        logic [3:0] pin_polarity;
        logic [3:0] pin_direction;
        logic locked;
    } cfg_out_t;

endpackage

// File: meas_tick_gen.sv
// Measurement tick generator: one pulse per measurement interval
`timescale 1ns/1ps
module meas_tick_gen
    import fan_cfg_pkg::*;
#(
    parameter int SLOW_CYCLES = SLOW_MEAS_CYCLES,
    parameter int FAST_CYCLES = FAST_MEAS_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic quick,
    output logic tick
);
    initial begin
        if (FAST_CYCLES < 1 || SLOW_CYCLES < FAST_CYCLES || SLOW_CYCLES >= 2**25) begin
            $error("meas_tick_gen: bad cycle counts");
        end
    end

    typedef struct packed {
        logic [24:0] cnt;
        logic tick;
    } tick_state_t;

    tick_state_t s_q;
    tick_state_t s_d;
    logic [24:0] limit;

    always_comb begin
        limit = quick ? 25'(FAST_CYCLES - 1) : 25'(SLOW_CYCLES - 1);
        s_d = s_q;
        s_d.tick = 1'b0;
        if (s_q.cnt >= limit) begin
            s_d.cnt = '0;
            s_d.tick = 1'b1;
        end else begin
            s_d.cnt = s_q.cnt + 25'd1;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else if (clk_en) begin
            s_q <= s_d;
        end
    end

    assign tick = s_q.tick;
endmodule

// File: fan_host_model.sv
// Host model: register port master issuing single byte writes and reads
`timescale 1ns/1ps
module fan_host_model (
    input wire logic ref_clk,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire logic [7:0] reg_rdata
);
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    // Idle bus shows the inverted address, and inverted data after a write (reads leave data as is), never the last request
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        @(posedge ref_clk);
        d = reg_rdata;
    endtask
endmodule

// File: fan_monitor_config_regs_sva.sv
// Checker: port assertions of the fan monitor configuration bank
`timescale 1ns/1ps
module fan_monitor_config_regs_sva
    import fan_cfg_pkg::*;
#(
    parameter int SLOW_CYCLES = SLOW_MEAS_CYCLES,
    parameter int FAST_CYCLES = FAST_MEAS_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic fan_full_speed,
    input wire logic pwm_high_freq,
    input wire logic [1:0] speed_pulse_window,
    input wire logic [7:0] pulse_stretch_en,
    input wire logic meas_tick,
    input wire logic pin_enable,
    input wire logic [3:0] pin1_4_polarity,
    input wire logic [3:0] pin1_4_direction,
    input wire logic intrusion_latch_clear,
    input wire logic config_locked
);
    logic w02;
    logic w03;
    assign w02 = reg_wr && clk_en && !config_locked && reg_addr == OFF_FAN_PWM_CONFIG;
    assign w03 = reg_wr && clk_en && !config_locked && reg_addr == OFF_MISC_SYSTEM_CONFIG;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    a_pwm_mode: assert property (w02 |=>
        pwm_high_freq == $past(reg_wdata[BIT_PWM_HIGH_FREQ])) else $error("pwm mode wrong");
    a_window_code: assert property (w02 |=>
        speed_pulse_window == $past(reg_wdata[7:6])) else $error("pulse window wrong");
    a_full_write: assert property (w02 && reg_wdata[BIT_FANS_FULL_SPEED] ##1 clk_en
        |-> ##1 fan_full_speed) else $error("full speed missing");
    a_clear_pulse: assert property (w03 && reg_wdata[BIT_INTRUSION_CLEAR] ##1 clk_en
        |-> ##1 intrusion_latch_clear) else $error("intrusion clear missing");
    a_pins_gated: assert property (!pin_enable [*2] |->
        pin1_4_polarity == 4'h0 && pin1_4_direction == 4'h0) else $error("pins not gated");
    a_stretch_hf: assert property (pwm_high_freq [*2] |->
        pulse_stretch_en == 8'h00) else $error("stretch in fast mode");
    a_tick_spacing: assert property (meas_tick && clk_en |=> !meas_tick [*8])
        else $error("ticks too close");
    a_lock_sticks: assert property (config_locked |=> config_locked)
        else $error("lock dropped");
    a_locked_hold: assert property (config_locked && reg_wr
        && reg_addr == OFF_FAN_PWM_CONFIG |=> $stable(pwm_high_freq)
        && $stable(speed_pulse_window)) else $error("locked write took effect");
    c_full: cover property (fan_full_speed);
    c_clear: cover property (intrusion_latch_clear);
    c_locked_wr: cover property (config_locked && reg_wr);
endmodule
bind fan_monitor_config_regs fan_monitor_config_regs_sva #(
    .SLOW_CYCLES(SLOW_CYCLES), .FAST_CYCLES(FAST_CYCLES)) sva_i (.ref_clk, .rst, .clk_en,
    .reg_addr, .reg_wdata, .reg_wr, .fan_full_speed, .pwm_high_freq, .speed_pulse_window,
    .pulse_stretch_en, .meas_tick, .pin_enable, .pin1_4_polarity, .pin1_4_direction,
    .intrusion_latch_clear, .config_locked);

// File: fan_monitor_config_regs_tb.sv
// Testbench: scenario tasks for the fan monitor configuration bank
`timescale 1ns/1ps
module fan_monitor_config_regs_tb;
    import fan_cfg_pkg::*;
    localparam int SLOW = 40;
    localparam int FAST = 10;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic clk_en = 1'b1;
    logic regulator_hot_input_1 = 1'b0;
    logic regulator_hot_input_2 = 1'b0;
    logic [7:0] fan_speed_pulse_input = 8'h00;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, pulse_measure_en, pulse_stretch_en;
    logic [7:0] pulse_measure_edge;
    logic [3:0] pin1_4_polarity, pin1_4_direction;
    logic [1:0] speed_pulse_window;
    logic reg_wr, reg_rd, fan_full_speed, pwm_high_freq, meas_tick, pin_enable;
    logic scl_timeout_en, sda_timeout_en, intrusion_latch_clear, parity_chain_test;
    logic config_locked;
    int num_errors = 0;
    int checked = 0;
    fan_host_model host (.ref_clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
    fan_monitor_config_regs #(.SLOW_CYCLES(SLOW), .FAST_CYCLES(FAST)) DUT (
        .ref_clk, .rst, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .regulator_hot_input_1, .regulator_hot_input_2, .fan_speed_pulse_input,
        .fan_full_speed, .pwm_high_freq, .speed_pulse_window, .pulse_measure_en,
        .pulse_stretch_en, .pulse_measure_edge, .meas_tick, .pin_enable, .pin1_4_polarity,
        .pin1_4_direction, .scl_timeout_en, .sda_timeout_en, .intrusion_latch_clear,
        .parity_chain_test, .config_locked);
    initial begin
        forever #25 ref_clk = ~ref_clk;
    end
    task chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        host.rd(a, d);
        chk(d, exp);
    endtask
    task t_reset;
        rd_chk(OFF_FAN_PWM_CONFIG, 8'h80);
        rd_chk(OFF_MISC_SYSTEM_CONFIG, 8'h00);
        rd_chk(OFF_FAN_PULSE_ENABLE, 8'h00);
        rd_chk(OFF_FAN_PULSE_CONFIG, 8'h0f);
        rd_chk(OFF_PIN_POLARITY_DIRECTION_1, 8'h00);
        rd_chk(8'h05, 8'h00);
    endtask
    task t_regs;
        logic [7:0] offs [4];
        offs = '{OFF_FAN_PWM_CONFIG, OFF_FAN_PULSE_ENABLE, OFF_FAN_PULSE_CONFIG,
            OFF_PIN_POLARITY_DIRECTION_1};
        foreach (offs[i]) begin
            host.wr(offs[i], 8'h5a);
            host.wr(offs[i], 8'ha5);
            rd_chk(offs[i], offs[i] == OFF_FAN_PULSE_CONFIG ? 8'h05 : 8'ha5);
        end
        chk(8'({pin1_4_direction, pin1_4_polarity}), 8'h00);
    endtask
    task t_ctrl;
        host.wr(OFF_FAN_PWM_CONFIG, 8'h24);
        repeat (3) @(posedge ref_clk);
        chk(8'({pwm_high_freq, fan_full_speed}), 8'h03);
        chk(pulse_stretch_en, 8'h00);
        host.wr(OFF_FAN_PWM_CONFIG, 8'h00);
        repeat (3) @(posedge ref_clk);
        chk(pulse_stretch_en, 8'haa);
        chk(8'(fan_full_speed), 8'h00);
        for (int c = 0; c < 4; c++) begin
            host.wr(OFF_FAN_PWM_CONFIG, {2'(c), 6'h00});
            repeat (2) @(posedge ref_clk);
            chk(8'(speed_pulse_window), 8'(c));
        end
    endtask
    task t_hot(input logic [7:0] ign, input logic sel);
        host.wr(OFF_FAN_PWM_CONFIG, ign ^ 8'h18);
        regulator_hot_input_1 <= !sel;
        regulator_hot_input_2 <= sel;
        repeat (6) @(posedge ref_clk);
        chk(8'(fan_full_speed), 8'h01);
        host.wr(OFF_FAN_PWM_CONFIG, ign);
        repeat (3) @(posedge ref_clk);
        chk(8'(fan_full_speed), 8'h00);
        regulator_hot_input_1 <= 1'b0;
        regulator_hot_input_2 <= 1'b0;
    endtask
    task t_misc;
        int seen;
        seen = 0;
        host.wr(OFF_MISC_SYSTEM_CONFIG, 8'h67);
        repeat (4) begin
            @(posedge ref_clk);
            seen += intrusion_latch_clear;
        end
        chk(8'(seen), 8'h01);
        chk(8'({pin_enable, scl_timeout_en, sda_timeout_en, parity_chain_test}), 8'h0f);
        chk(8'({pin1_4_direction, pin1_4_polarity}), 8'hc3);
        rd_chk(OFF_MISC_SYSTEM_CONFIG, 8'h47);
        host.wr(OFF_MISC_SYSTEM_CONFIG, 8'h00);
        repeat (3) @(posedge ref_clk);
        chk(8'({pin_enable, scl_timeout_en, sda_timeout_en, parity_chain_test}), 8'h00);
        chk(8'({pin1_4_direction, pin1_4_polarity}), 8'h00);
    endtask
    task t_pulse;
        logic [7:0] acc;
        acc = 8'h00;
        host.wr(OFF_FAN_PULSE_ENABLE, 8'h01);
        repeat (2) @(posedge ref_clk);
        chk(pulse_measure_en, 8'h01);
        fan_speed_pulse_input <= 8'h03;
        repeat (8) begin
            @(posedge ref_clk);
            acc = acc | pulse_measure_edge;
        end
        chk(acc, 8'h01);
        fan_speed_pulse_input <= 8'h00;
    endtask
    // Gap between two ticks, with clk_en held low for stall cycles inside it
    task tick_gap(input int stall, input int exp);
        int n;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (meas_tick !== 1'b1 && n < 200);
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
            if (n == 3 && stall > 0) clk_en <= 1'b0;
            if (n == 3 + stall) clk_en <= 1'b1;
        end while (meas_tick !== 1'b1 && n < 200);
        chk(8'(n), 8'(exp));
    endtask
    task t_tick;
        host.wr(OFF_FAN_PWM_CONFIG, 8'h00);
        tick_gap(0, SLOW);
        host.wr(OFF_FAN_PWM_CONFIG, 8'h01);
        tick_gap(0, FAST);
        tick_gap(5, FAST + 5);
    endtask
    task t_soft;
        host.wr(OFF_MISC_SYSTEM_CONFIG, 8'h46);
        host.wr(OFF_SOFT_RESET_UNLOCK, SOFT_RESET_KEY);
        host.wr(OFF_SOFT_RESET_UNLOCK, 8'h00);
        host.wr(OFF_SOFT_RESET_CTRL, 8'h80);
        rd_chk(OFF_FAN_PWM_CONFIG, 8'h01);
        host.wr(OFF_SOFT_RESET_UNLOCK, SOFT_RESET_KEY);
        host.wr(OFF_SOFT_RESET_CTRL, 8'h80);
        rd_chk(OFF_FAN_PWM_CONFIG, 8'h80);
        rd_chk(OFF_MISC_SYSTEM_CONFIG, 8'h00);
        rd_chk(OFF_FAN_PULSE_ENABLE, 8'h00);
        rd_chk(OFF_FAN_PULSE_CONFIG, 8'h0f);
        rd_chk(OFF_PIN_POLARITY_DIRECTION_1, 8'h00);
    endtask
    task t_lock;
        host.wr(OFF_FAN_PWM_CONFIG, 8'h24);
        host.wr(OFF_LOCK_CTRL, 8'h40);
        host.wr(OFF_FAN_PWM_CONFIG, 8'h00);
        host.wr(OFF_FAN_PULSE_CONFIG, 8'h00);
        host.wr(OFF_SOFT_RESET_UNLOCK, SOFT_RESET_KEY);
        host.wr(OFF_SOFT_RESET_CTRL, 8'h80);
        rd_chk(OFF_FAN_PWM_CONFIG, 8'h24);
        rd_chk(OFF_FAN_PULSE_CONFIG, 8'h0f);
        rd_chk(OFF_LOCK_CTRL, 8'h40);
        chk(8'({config_locked, pwm_high_freq}), 8'h03);
    endtask
    task print_verdict;
        $display("Comparisons %0d, errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge ref_clk);
        num_errors++;
        print_verdict();
    end
    initial begin
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        t_reset();
        t_regs();
        t_ctrl();
        t_hot(8'h08, 1'b0);
        t_hot(8'h10, 1'b1);
        t_misc();
        t_pulse();
        t_tick();
        t_soft();
        t_lock();
        // Mid-run reset clears the lock and restores defaults
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        t_reset();
        chk(8'(config_locked), 8'h00);
        print_verdict();
    end
endmodule
